// file: hdl/ubsl_pkg.sv
// Constants and types for the USB device bus-state block
`default_nettype none
package ubsl_pkg;
  localparam int FRAME_NS      = 1000000;
  localparam int CLK_NS        = 4;
  localparam int MS_CYC        = FRAME_NS / CLK_NS;
  localparam int SUSP_IDLE_MS  = 3;
  localparam int LOWP_MAX_MS   = 10;
  localparam int WAKE_MAX_MS   = 10;
  localparam int RESUME_MS     = 1;
  localparam int NUM_EP        = 16;
  localparam int ISO_MAX_BYTES = 1023;
  localparam int DEF_ADDR      = 0;
  localparam int CTRL_EP       = 0;
  localparam logic [4:0] CRC5_INIT = 5'h1f;
  localparam logic [4:0] CRC5_POLY = 5'h05;
  localparam logic [4:0] DEV_DSC_LEN = 5'h12;
  localparam logic [4:0] STR0_LEN    = 5'h04;
  localparam logic [4:0] STR1_LEN    = 5'h08;
  localparam logic [7:0] DSC_DEVICE  = 8'h01;
  localparam logic [7:0] DSC_STRING  = 8'h03;
  typedef enum logic [1:0] {
    UBSL_CTRL, UBSL_ISO, UBSL_BULK, UBSL_INTR
  } ubsl_xfer_type;
  typedef enum logic [1:0] {
    UBSL_DSC_DEV, UBSL_DSC_STR0, UBSL_DSC_STR1, UBSL_DSC_NONE
  } ubsl_dsc_type;
endpackage
`default_nettype wire

// file: hdl/ubsl_top.sv
// USB device bus-state logic with its receive FIFO
// Summary of operation
// - At most sixteen bidirectional endpoints exist and data moves per endpoint.
// - Endpoint 0 is always a control endpoint and is usable as soon as the device is attached.
// - Isochronous payloads take up to 1023 bytes and are never handshaken or retried.
// - At low speed only interrupt and control transfers are accepted.
// - Suspend is entered after 3 ms without a start-of-frame token, bus activity or bus reset.
// - Consumption is reduced no later than 10 ms after suspend begins.
// - Wake-up signalling starts within 10 ms of leaving the low-power state.
// - A bus reset returns the device to unconfigured and to address zero.
// - After Set Address the device answers only its assigned address.
// - Exactly one device descriptor gives maker, product, serial, class and configurations.
// - String descriptors are returned as unicode text.
// - Attach enables the pull-up on D+ for full speed or on D- for low speed.
// - Token CRC5 is checked in hardware.
// - Full speed needs the 48 MHz module clock to be present.
`default_nettype none

module ubsl_fifo import ubsl_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = wr_valid && wr_ready;
  wire              pop  = rd_valid && rd_ready;
  assign wr_ready = cnt_r != (AW+1)'(DEPTH);
  assign rd_valid = cnt_r != '0;
  assign rd_data  = mem[rp_r];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr_data;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= push ? wp_r + 1'b1 : wp_r;
      rp_r  <= pop ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ubsl_top import ubsl_pkg::*; #(
  parameter int          MS_CYCLES  = MS_CYC,
  parameter int          LOWP_MS    = 1,
  parameter int          WAKE_MS    = 2,
  parameter logic [15:0] VENDOR_ID  = 16'h1234, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        pin_se0,
  input  wire logic        pin_active,
  input  wire logic        full_speed_sel,
  input  wire logic        clk48_ok,
  input  wire logic        attach_en,
  input  wire logic        wake_req,
  input  wire logic        sof_valid,
  input  wire logic [10:0] sof_frame,
  input  wire logic        tok_valid,
  input  wire logic [6:0]  tok_addr,
  input  wire logic [3:0]  tok_endp,
  input  wire logic [4:0]  tok_crc5,
  input  wire logic [1:0]  tok_xfer,
  input  wire logic [15:0] ep_enable,
  input  wire logic        set_addr_done,
  input  wire logic [6:0]  set_addr_val,
  input  wire logic        set_cfg_done,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       out_data,
  output logic             out_last,
  output logic             out_valid,
  input  wire logic        out_ready,
  input  wire logic [1:0]  dsc_sel,
  input  wire logic [4:0]  dsc_idx,
  output logic [7:0]       dsc_byte,
  output logic             dsc_ok,
  output logic             tok_accept,
  output logic             hs_req,
  output logic             iso_over,
  output logic [6:0]       dev_addr,
  output logic             configured,
  output logic [10:0]      frame_num,
  output logic             suspended,
  output logic             low_power,
  output logic             resume_k,
  output logic             pullup_dp_en,
  output logic             pullup_dm_en
);
  typedef enum logic [2:0] {
    ST_ACTIVE, ST_SUSP, ST_LOWP, ST_WAKE, ST_RESUME
  } ubsl_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and millisecond time base
  logic [1:0] se0_s_r;
  logic [1:0] act_s_r;
  logic       se0_d_r;
  logic [31:0] div_r;
  wire        ms_tick  = div_r == 32'(MS_CYCLES - 1);
  wire        bus_rst  = se0_s_r[1] && !se0_d_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      se0_s_r <= '0;
      act_s_r <= '0;
      se0_d_r <= 1'b0;
      div_r   <= '0;
    end else begin
      se0_s_r <= {se0_s_r[0], pin_se0};
      act_s_r <= {act_s_r[0], pin_active};
      se0_d_r <= se0_s_r[1];
      div_r   <= ms_tick ? '0 : div_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed and attach
  // full speed gate
  wire full_spd = full_speed_sel && clk48_ok;
  assign pullup_dp_en = attach_en && full_spd;
  assign pullup_dm_en = attach_en && !full_spd;

  ////////////////////////////////////////////////////////////////////////////
  // Suspend, low power and wake-up
  ubsl_state_type st_r;
  ubsl_state_type st_nxt;
  logic [3:0] idle_ms_r;
  logic [3:0] st_ms_r;
  wire activity = sof_valid || act_s_r[1] || bus_rst;
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_ACTIVE: begin
        if (!activity && ms_tick && idle_ms_r == 4'(SUSP_IDLE_MS - 1)) begin
          st_nxt = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (activity) begin
          st_nxt = ST_ACTIVE;
        end else if (ms_tick && st_ms_r == 4'(LOWP_MS - 1)) begin
          st_nxt = ST_LOWP;
        end
      end
      ST_LOWP: begin
        if (activity) begin
          st_nxt = ST_ACTIVE;
        end else if (wake_req) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (ms_tick && st_ms_r == 4'(WAKE_MS - 1)) begin
          st_nxt = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (ms_tick && st_ms_r == 4'(RESUME_MS - 1)) begin
          st_nxt = ST_ACTIVE;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r      <= ST_ACTIVE;
      idle_ms_r <= '0;
      st_ms_r   <= '0;
    end else begin
      st_r      <= st_nxt;
      idle_ms_r <= (activity || st_r != ST_ACTIVE) ? '0
                 : ms_tick ? idle_ms_r + 1'b1 : idle_ms_r;
      st_ms_r   <= (st_nxt != st_r) ? '0 : ms_tick ? st_ms_r + 1'b1 : st_ms_r;
    end
  end
  assign suspended = st_r == ST_SUSP || st_r == ST_LOWP;
  assign low_power = st_r == ST_LOWP;
  assign resume_k  = st_r == ST_RESUME;

  ////////////////////////////////////////////////////////////////////////////
  // Address, configuration and frame number
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dev_addr   <= 7'(DEF_ADDR);
      configured <= 1'b0;
      frame_num  <= '0;
    end else begin
      if (bus_rst) begin
        dev_addr   <= 7'(DEF_ADDR);
        configured <= 1'b0;
      end else begin
        if (set_addr_done) begin
          dev_addr <= set_addr_val;
        end
        if (set_cfg_done) begin
          configured <= 1'b1;
        end
      end
      if (sof_valid) begin
        frame_num <= sof_frame;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Token check
  function automatic logic [4:0] crc5(input logic [10:0] d);
    logic [4:0] c;
    logic       fb;
    c = CRC5_INIT;
    for (int i = 0; i < 11; i++) begin
      fb = d[i] ^ c[4];
      c  = {c[3:0], 1'b0} ^ (fb ? CRC5_POLY : 5'h00);
    end
    return ~c;
  endfunction
  wire crc_ok  = crc5({tok_endp, tok_addr}) == tok_crc5;
  wire addr_ok = tok_addr == dev_addr;
  wire ep_ok   = 32'(tok_endp) < NUM_EP && ep_enable[tok_endp];
  wire ep0_ok  = tok_endp == 4'(CTRL_EP) && tok_xfer == UBSL_CTRL;
  wire type_ok = full_spd || tok_xfer == UBSL_CTRL || tok_xfer == UBSL_INTR;
  wire tok_go  = tok_valid && crc_ok && addr_ok && type_ok && !suspended
               && (tok_endp == 4'(CTRL_EP) ? ep0_ok : ep_ok);

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  logic        open_r;
  logic        iso_r;
  logic [10:0] cnt_r;
  logic        f_ready;
  wire         cnt_full = cnt_r == 11'(ISO_MAX_BYTES);
  wire         drop     = !open_r || (iso_r && cnt_full);
  wire         push     = rx_valid && !drop;
  wire         take     = rx_valid && rx_ready;
  assign rx_ready = drop || f_ready;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      open_r     <= 1'b0;
      iso_r      <= 1'b0;
      cnt_r      <= '0;
      tok_accept <= 1'b0;
      hs_req     <= 1'b0;
      iso_over   <= 1'b0;
    end else begin
      tok_accept <= tok_go;
      hs_req     <= 1'b0;
      iso_over   <= 1'b0;
      if (tok_go) begin
        open_r <= 1'b1;
        iso_r  <= tok_xfer == UBSL_ISO;
        cnt_r  <= '0;
      end else if (take && open_r) begin
        cnt_r <= cnt_full ? cnt_r : cnt_r + 1'b1;
        if (iso_r && cnt_full) begin
          iso_over <= 1'b1;
        end
        if (rx_last) begin
          open_r <= 1'b0;
          hs_req <= !iso_r;
        end
      end
    end
  end
  ubsl_fifo #(
    .WIDTH (9),
    .DEPTH (4)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wr_data  ({rx_last, rx_data}),
    .wr_valid (push),
    .wr_ready (f_ready),
    .rd_data  ({out_last, out_data}),
    .rd_valid (out_valid),
    .rd_ready (out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor store
  // single device descriptor
  function automatic logic [7:0] dev_dsc(input logic [4:0] i);
    unique case (i)
      5'h00:   return 8'(DEV_DSC_LEN);
      5'h01:   return DSC_DEVICE;
      5'h03:   return 8'h02;
      5'h07:   return 8'h40;
      5'h08:   return VENDOR_ID[7:0];
      5'h09:   return VENDOR_ID[15:8];
      5'h0a:   return PRODUCT_ID[7:0];
      5'h0b:   return PRODUCT_ID[15:8];
      5'h0d:   return 8'h01;
      5'h0e:   return 8'h01;
      5'h0f:   return 8'h01;
      5'h10:   return 8'h01;
      5'h11:   return 8'h01;
      default: return 8'h00;
    endcase
  endfunction
  wire [7:0] str0 = dsc_idx[1:0] == 2'h0 ? 8'(STR0_LEN) : dsc_idx[1:0] == 2'h1
                  ? DSC_STRING : dsc_idx[1:0] == 2'h2 ? 8'h09 : 8'h04;
  wire [7:0] str1 = dsc_idx[0] ? 8'h00 : dsc_idx[2:1] == 2'h0 ? 8'(STR1_LEN)
                  : dsc_idx[2:1] == 2'h1 ? 8'h55 : dsc_idx[2:1] == 2'h2 ? 8'h53 : 8'h42;
  wire [7:0] str1b = dsc_idx == 5'h01 ? DSC_STRING : str1;
  wire in_dev  = dsc_sel == UBSL_DSC_DEV && dsc_idx < DEV_DSC_LEN;
  wire in_s0   = dsc_sel == UBSL_DSC_STR0 && dsc_idx < STR0_LEN;
  wire in_s1   = dsc_sel == UBSL_DSC_STR1 && dsc_idx < STR1_LEN;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dsc_byte <= '0;
      dsc_ok   <= 1'b0;
    end else begin
      dsc_ok   <= in_dev || in_s0 || in_s1;
      dsc_byte <= in_dev ? dev_dsc(dsc_idx) : in_s0 ? str0 : in_s1 ? str1b : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [31:0] susp_cyc_r;
  always_ff @(posedge clk) begin
    if (sys_rst || !suspended || st_r == ST_LOWP) begin
      susp_cyc_r <= '0;
    end else begin
      susp_cyc_r <= susp_cyc_r + 1'b1;
    end
  end
  chk_lowp_deadline: assert property (@(posedge clk) disable iff (sys_rst)
    susp_cyc_r <= 32'(LOWP_MAX_MS * MS_CYCLES))
    else $error("low power not reached in time");
  chk_wake_deadline: assert property (@(posedge clk) disable iff (sys_rst)
    st_r == ST_WAKE |-> 32'(st_ms_r) < WAKE_MAX_MS)
    else $error("wake signalling late");
  chk_susp_idle: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(suspended) |-> $past(idle_ms_r) == 4'(SUSP_IDLE_MS - 1) && !$past(activity))
    else $error("suspend without full idle time");
  chk_act_restart: assert property (@(posedge clk) disable iff (sys_rst)
    activity && st_r == ST_ACTIVE |=> idle_ms_r == '0)
    else $error("idle timer not restarted");
  chk_reset_addr: assert property (@(posedge clk) disable iff (sys_rst)
    bus_rst |=> dev_addr == 7'(DEF_ADDR) && !configured)
    else $error("bus reset did not clear address");
  chk_set_addr: assert property (@(posedge clk) disable iff (sys_rst)
    set_addr_done && !bus_rst |=> dev_addr == $past(set_addr_val))
    else $error("address not adopted");
  chk_addr_match: assert property (@(posedge clk) disable iff (sys_rst)
    tok_accept |-> $past(tok_addr) == $past(dev_addr))
    else $error("token accepted for foreign address");
  chk_low_types: assert property (@(posedge clk) disable iff (sys_rst)
    tok_accept && !$past(full_spd) |-> $past(tok_xfer) inside {UBSL_CTRL, UBSL_INTR})
    else $error("low speed accepted bulk or iso");
  chk_iso_nohs: assert property (@(posedge clk) disable iff (sys_rst)
    hs_req |-> !iso_r && $past(take && rx_last && open_r))
    else $error("handshake on isochronous");
  chk_pullup_side: assert property (@(posedge clk) disable iff (sys_rst)
    !(pullup_dp_en && pullup_dm_en) && (attach_en == (pullup_dp_en || pullup_dm_en)))
    else $error("pull-up selection wrong");
  cov_suspend: cover property (@(posedge clk) disable iff (sys_rst) $rose(low_power));
  cov_resume: cover property (@(posedge clk) disable iff (sys_rst) $fell(resume_k));
  cov_token: cover property (@(posedge clk) disable iff (sys_rst) tok_accept ##[1:40] hs_req);
  cov_setaddr: cover property (@(posedge clk) disable iff (sys_rst)
    bus_rst ##[1:100] set_addr_done);
endmodule
`default_nettype wire

// file: hdl/ubsl_dummy_none.sv
// Intentionally empty unit
`default_nettype none
`default_nettype wire

// file: tb/ubsl_host_model.sv
// Host-side model: frame markers and a stallable byte sink
`default_nettype none
module ubsl_host_model import ubsl_pkg::*; #(
  parameter int MS = 20
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sof_on,
  input  wire logic        stall,
  input  wire logic [7:0]  out_data,
  input  wire logic        out_last,
  input  wire logic        out_valid,
  output logic             out_ready,
  output logic             sof_valid,
  output logic [10:0]      sof_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt_r;
  logic [10:0] frame_r;
  logic [8:0]  got[$];
  assign out_ready = !stall;
  // Frame number only meaningful with its marker
  assign sof_frame = sof_valid ? frame_r : ~frame_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      frame_r <= 11'h000;
    end
    if (sys_rst || !sof_on) begin
      cnt_r     <= 0;
      sof_valid <= 1'b0;
    end else begin
      cnt_r     <= (cnt_r == MS - 1) ? 0 : cnt_r + 1;
      sof_valid <= (cnt_r == MS - 1);
      if (cnt_r == MS - 1) begin
        frame_r <= frame_r + 11'h001;
      end
    end
    if (out_valid && out_ready) begin
      got.push_back({out_last, out_data});
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_usb_device_bus_state_logic.sv
// Bench for the USB device bus-state logic
`default_nettype none
module tb_usb_device_bus_state_logic import ubsl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  logic        clk, sys_rst, pin_se0, pin_active, full_speed_sel, clk48_ok, attach_en;
  logic        wake_req, tok_valid, set_addr_done, set_cfg_done, rx_last, rx_valid;
  logic        stall, sof_on, rx_ready, out_last, out_valid, out_ready, dsc_ok;
  logic        tok_accept, hs_req, iso_over, configured, suspended, low_power, resume_k;
  logic        pullup_dp_en, pullup_dm_en, sof_valid;
  logic [6:0]  tok_addr, set_addr_val, dev_addr;
  logic [3:0]  tok_endp;
  logic [4:0]  tok_crc5, dsc_idx;
  logic [1:0]  tok_xfer, dsc_sel;
  logic [15:0] ep_enable;
  logic [7:0]  rx_data, out_data, dsc_byte;
  logic [10:0] sof_frame, frame_num;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          iso_drops = 0;

  ubsl_top #(.MS_CYCLES(MS)) dut_u (
    .clk, .sys_rst, .pin_se0, .pin_active, .full_speed_sel, .clk48_ok, .attach_en,
    .wake_req, .sof_valid, .sof_frame, .tok_valid, .tok_addr, .tok_endp, .tok_crc5,
    .tok_xfer, .ep_enable, .set_addr_done, .set_addr_val, .set_cfg_done, .rx_data,
    .rx_last, .rx_valid, .rx_ready, .out_data, .out_last, .out_valid, .out_ready,
    .dsc_sel, .dsc_idx, .dsc_byte, .dsc_ok, .tok_accept, .hs_req, .iso_over, .dev_addr,
    .configured, .frame_num, .suspended, .low_power, .resume_k, .pullup_dp_en,
    .pullup_dm_en
  );
  ubsl_host_model #(.MS(MS)) host_u (
    .clk, .sys_rst, .sof_on, .stall, .out_data, .out_last, .out_valid, .out_ready,
    .sof_valid, .sof_frame
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (iso_over === 1'b1) iso_drops++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int w = 0; w < lim && s !== 1'b1; w++) step(1);
  endtask
  function automatic logic [4:0] crc5(input logic [10:0] d);
    logic [4:0] c;
    c = CRC5_INIT;
    for (int i = 0; i < 11; i++) c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? CRC5_POLY : 5'h00);
    return ~c;
  endfunction
  task automatic tok(input logic [6:0] a, input logic [3:0] e, input logic [1:0] x,
                     input logic bad, input logic exp);
    tok_addr  = a;
    tok_endp  = e;
    tok_xfer  = x;
    tok_crc5  = crc5({e, a}) ^ {4'h0, bad};
    tok_valid = 1'b1;
    step(1);
    chk(tok_accept, exp);
    tok_valid = 1'b0;
    tok_addr  = ~a;
    step(1);
  endtask
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      rx_data  = i[7:0];
      rx_last  = (i == n - 1);
      rx_valid = 1'b1;
      for (int w = 0; w < 200 && rx_ready !== 1'b1; w++) step(1);
      step(1);
    end
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
  task automatic dsc(input logic [1:0] s, input logic [4:0] i, input logic ok,
                     input logic [7:0] b);
    dsc_sel = s;
    dsc_idx = i;
    step(1);
    chk(dsc_ok, ok);
    if (ok) chk(dsc_byte, b);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_pullup;
    logic fs;
    chk(dev_addr, 7'h00);
    chk(configured, 1'b0);
    chk(suspended, 1'b0);
    for (int i = 0; i < 8; i++) begin
      {attach_en, full_speed_sel, clk48_ok} = i[2:0];
      step(1);
      fs = i[1] & i[0];
      chk(pullup_dp_en, i[2] & fs);
      chk(pullup_dm_en, i[2] & !fs);
    end
    $display("test reset_pullup done");
  endtask
  task automatic t_tokens;
    tok(7'h00, 4'h0, 2'h0, 1'b0, 1'b1);
    tok(7'h00, 4'h0, 2'h0, 1'b1, 1'b0);
    tok(7'h05, 4'h0, 2'h0, 1'b0, 1'b0);
    tok(7'h00, 4'h0, 2'h2, 1'b0, 1'b0);
    tok(7'h00, 4'h5, 2'h2, 1'b0, 1'b0);
    ep_enable = 16'h8008;
    tok(7'h00, 4'hf, 2'h3, 1'b0, 1'b1);
    for (int s = 0; s < 2; s++) begin
      clk48_ok = s[0];
      for (int x = 0; x < 4; x++) tok(7'h00, 4'h3, x[1:0], 1'b0, s[0] | (x[1] == x[0]));
    end
    $display("test tokens done");
  endtask
  task automatic t_payload;
    stall = 1'b1;
    host_u.got.delete();
    tok(7'h00, 4'h0, 2'h0, 1'b0, 1'b1);
    fork
      begin
        send(6);
        chk(hs_req, 1'b1);
      end
      begin
        step(10);
        chk(rx_ready, 1'b0);
        stall = 1'b0;
      end
    join
    step(8);
    chk(16'(host_u.got.size()), 16'h0006);
    foreach (host_u.got[i]) chk({7'h00, host_u.got[i]}, {7'h00, i == 5, i[7:0]});
    $display("test payload done");
  endtask
  task automatic t_iso;
    tok(7'h00, 4'h3, 2'h1, 1'b0, 1'b1);
    host_u.got.delete();
    iso_drops = 0;
    send(1025);
    chk(hs_req, 1'b0);
    step(8);
    chk(16'(host_u.got.size()), 16'h03ff);
    chk(16'(iso_drops), 16'h0002);
    $display("test iso done");
  endtask
  task automatic t_addr;
    set_addr_val = 7'h2a;
    pulse(set_addr_done);
    chk(dev_addr, 7'h2a);
    tok(7'h00, 4'h0, 2'h0, 1'b0, 1'b0);
    tok(7'h2a, 4'h0, 2'h0, 1'b0, 1'b1);
    pulse(set_cfg_done);
    chk(configured, 1'b1);
    pin_se0 = 1'b1;
    step(5);
    pin_se0 = 1'b0;
    step(1);
    chk(dev_addr, 7'h00);
    chk(configured, 1'b0);
    tok(7'h00, 4'h0, 2'h0, 1'b0, 1'b1);
    set_addr_val = 7'h11;
    pulse(set_addr_done);
    chk(dev_addr, 7'h11);
    $display("test addr done");
  endtask
  task automatic t_dsc;
    dsc(2'h0, 5'h00, 1'b1, {3'h0, DEV_DSC_LEN});
    dsc(2'h0, 5'h01, 1'b1, DSC_DEVICE);
    dsc(2'h0, 5'h03, 1'b1, 8'h02);
    dsc(2'h0, 5'h11, 1'b1, 8'h01);
    dsc(2'h0, 5'h12, 1'b0, 8'h00);
    dsc(2'h1, 5'h01, 1'b1, DSC_STRING);
    dsc(2'h1, 5'h04, 1'b0, 8'h00);
    dsc(2'h2, 5'h02, 1'b1, 8'h55);
    dsc(2'h2, 5'h03, 1'b1, 8'h00);
    dsc(2'h2, 5'h06, 1'b1, 8'h42);
    dsc(2'h2, 5'h08, 1'b0, 8'h00);
    dsc(2'h3, 5'h00, 1'b0, 8'h00);
    $display("test dsc done");
  endtask
  task automatic t_suspend;
    wait_hi(sof_valid, 2 * MS);
    step(2);
    chk(frame_num, host_u.frame_r);
    sof_on = 1'b0;
    step(MS + MS / 2);
    chk(suspended, 1'b0);
    wait_hi(suspended, 3 * MS);
    chk(suspended, 1'b1);
    wait_hi(low_power, 2 * MS + 4);
    chk(low_power, 1'b1);
    pulse(wake_req);
    chk(low_power, 1'b0);
    wait_hi(resume_k, 3 * MS + 4);
    chk(resume_k, 1'b1);
    step(MS + MS / 4);
    chk(resume_k, 1'b0);
    chk(suspended, 1'b0);
    wait_hi(suspended, 5 * MS);
    chk(suspended, 1'b1);
    pin_active = 1'b1;
    step(6);
    chk(suspended, 1'b0);
    pin_active = 1'b0;
    sof_on = 1'b1;
    $display("test suspend done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {pin_se0, pin_active, wake_req, tok_valid, set_addr_done, set_cfg_done} = '0;
    {tok_addr, tok_endp, tok_crc5, tok_xfer, set_addr_val, rx_data, dsc_sel, dsc_idx} = '0;
    {rx_last, rx_valid, stall} = '0;
    {full_speed_sel, clk48_ok, attach_en, sof_on, sys_rst} = 5'h1f;
    ep_enable = 16'h0008;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset_pullup();
    t_tokens();
    t_payload();
    t_iso();
    t_addr();
    t_dsc();
    t_suspend();
    end_of_test();
  end
  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
